/* File: logic/srg_group.sv */
// One status register group: condition, two edge filters, event, mask.
// Assumes condition inputs come from logic on the same clock.
`timescale 1ns/100ps
module srg_group #(
  parameter logic [15:0] USED = 16'hFFFF
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic [15:0] i_cond,
  input  wire logic [15:0] i_set,
  input  wire logic        i_clr_status,
  input  wire logic        i_reset_cmd,
  input  wire logic        i_rd_event,
  input  wire logic        i_wr_rise,
  input  wire logic        i_wr_fall,
  input  wire logic        i_wr_mask,
  input  wire logic [15:0] i_wdata,
  output logic      [15:0] o_cond,
  output logic      [15:0] o_rise,
  output logic      [15:0] o_fall,
  output logic      [15:0] o_event,
  output logic      [15:0] o_mask,
  output logic             o_summary
);

  typedef struct packed {
    logic [15:0] prev;
    logic [15:0] rise;
    logic [15:0] fall;
    logic [15:0] evt;
    logic [15:0] mask;
  } srg_grp_s;

  srg_grp_s    st_ff;
  srg_grp_s    nxt_st;
  logic [15:0] cond;
  logic [15:0] hits;

  // Live condition, unused bits forced low.
  assign cond = i_cond & USED;
  // Qualified edges plus direct events.
  assign hits = ((cond & ~st_ff.prev & st_ff.rise) |
                 (~cond & st_ff.prev & st_ff.fall) | i_set) & USED;

  // Next state; a new hit beats a clear so no event is lost.
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.prev = cond;
    if (i_reset_cmd) begin
      nxt_st.rise = srg_pkg::RISE_RST;
      nxt_st.fall = srg_pkg::FALL_RST;
    end else begin
      if (i_wr_rise) nxt_st.rise = i_wdata;
      if (i_wr_fall) nxt_st.fall = i_wdata;
    end
    if (i_clr_status || i_rd_event) begin
      nxt_st.evt = 16'h0000;
    end
    nxt_st.evt = nxt_st.evt | hits;
    if (i_wr_mask) nxt_st.mask = i_wdata & USED;
  end

  // Single register stage for the whole group.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_ff <= '{16'h0000, srg_pkg::RISE_RST, srg_pkg::FALL_RST,
                 16'h0000, 16'h0000};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_cond    = cond;
  assign o_rise    = st_ff.rise;
  assign o_fall    = st_ff.fall;
  assign o_event   = st_ff.evt & USED;
  assign o_mask    = st_ff.mask;
  assign o_summary = |(st_ff.evt & st_ff.mask);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  property p_hit_sets;
    hits != 16'h0000 |=> (o_event & $past(hits)) == $past(hits);
  endproperty
  a_hit_sets: assert property (p_hit_sets)
    else $error("Qualified edge did not latch an event bit.");

  property p_no_spurious;
    1'b1 |=> (o_event & ~$past(o_event) & ~$past(hits)) == 16'h0000;
  endproperty
  a_no_spurious: assert property (p_no_spurious)
    else $error("Event bit set without a qualified edge.");

  property p_evt_hold;
    !(i_clr_status || i_rd_event) |=>
      (o_event & $past(o_event)) == $past(o_event);
  endproperty
  a_evt_hold: assert property (p_evt_hold)
    else $error("Event bit dropped without query or clear.");

  property p_evt_clear;
    (i_clr_status || i_rd_event) && hits == 16'h0000 |=>
      o_event == 16'h0000;
  endproperty
  a_evt_clear: assert property (p_evt_clear)
    else $error("Event register not cleared.");

  property p_filt_keep;
    (i_clr_status || i_rd_event) && !i_wr_rise && !i_wr_fall &&
      !i_reset_cmd |=> $stable(o_rise) && $stable(o_fall);
  endproperty
  a_filt_keep: assert property (p_filt_keep)
    else $error("Edge filter changed on clear or query.");

  property p_mask_keep;
    !i_wr_mask |=> $stable(o_mask);
  endproperty
  a_mask_keep: assert property (p_mask_keep)
    else $error("Mask changed without a write.");

  property p_rst_cmd;
    i_reset_cmd |=> o_rise == 16'hFFFF && o_fall == 16'h0000;
  endproperty
  a_rst_cmd: assert property (p_rst_cmd)
    else $error("Reset command did not restore filters.");

  c_rise_evt: cover property (hits != 16'h0000 ##1 o_summary);
  c_clr_win: cover property (i_rd_event && hits != 16'h0000);

endmodule

/* File: logic/srg_pkg.sv */
// Shared constants for the status reporting register group block.
// Assumes a command decoder upstream that presents one decoded status
// command per cycle; no timescale since this file holds a package only.
package srg_pkg;

  // ****************************************************************
  // Widths and group indices
  // ****************************************************************
  localparam int NGRP     = 5;
  localparam int GW       = 16;
  localparam int GRP_OPER = 0;
  localparam int GRP_QUES = 1;
  localparam int GRP_HW1  = 2;
  localparam int GRP_HW2  = 3;
  localparam int GRP_STD  = 4;

  // ****************************************************************
  // Reset values and used-bit masks
  // ****************************************************************
  localparam logic [15:0] RISE_RST = 16'hFFFF;
  localparam logic [15:0] FALL_RST = 16'h0000;
  localparam logic [15:0] USED_16  = 16'hFFFF;
  localparam logic [15:0] USED_8   = 16'h00FF;
  localparam logic [15:0] USED_OPER = 16'h7FFF;

  // ****************************************************************
  // Status byte positions and masks
  // ****************************************************************
  localparam int SB_HW1  = 0;
  localparam int SB_HW2  = 1;
  localparam int SB_NONE = 2;
  localparam int SB_QUES = 3;
  localparam int SB_MAV  = 4;
  localparam int SB_STD  = 5;
  localparam int SB_RQS  = 6;
  localparam int SB_OPER = 7;
  localparam logic [7:0] SB_NOT_SUM = 8'hBF;
  localparam int QUES_ERRQ_BIT = 9;

  // ****************************************************************
  // Commands
  // ****************************************************************
  typedef enum logic [3:0] {
    CMD_RD_COND  = 4'h0,
    CMD_RD_RISE  = 4'h1,
    CMD_WR_RISE  = 4'h2,
    CMD_RD_FALL  = 4'h3,
    CMD_WR_FALL  = 4'h4,
    CMD_RD_EVENT = 4'h5,
    CMD_RD_MASK  = 4'h6,
    CMD_WR_MASK  = 4'h7,
    CMD_CLR_STAT = 4'h8,
    CMD_RESET    = 4'h9,
    CMD_STB_QRY  = 4'hA,
    CMD_SPOLL    = 4'hB,
    CMD_RD_SRE   = 4'hC,
    CMD_WR_SRE   = 4'hD,
    CMD_RD_ERRQ  = 4'hE
  } srg_cmd_e;

endpackage

/* File: logic/srg_top.sv */
// Status reporting hierarchy: five register groups, an error queue and
// the top summary byte, driven by decoded status commands.
// Assumes i_cmd_* and all status inputs come from logic on i_clk.
`timescale 1ns/100ps
// Overview of operation
// - Summary byte is read-only and built only from lower summaries.
// - Clear-status empties event registers and queues, not output queue.
// - Condition bits follow internal states live, read-only.
// - Condition registers are 16 bits; unassigned bits read zero.
// - Rising condition edge sets event only when rise filter bit set.
// - Falling condition edge sets event only when fall filter bit set.
// - Both filter bits catch either edge; neither catches none.
// - Both 16-bit filters read/write and survive clear and queries.
// - Reset loads rise filter all ones, fall filter all zeros.
// - Event bits stay set until queried or cleared by clear-status.
// - Further edges on an already set event bit are ignored.
// - Event registers are read-only, 8 or 16 bits, unused read zero.
// - Summary is OR of event bits ANDed with mask bits.
// - Masks read/write, sized to event register, unused bits dropped.
// - Masks unchanged by clear-status and by queries.
// - Each group summary is a bit of a higher register.
// - Queue summary is one while queue holds an entry.
// - Reading out every entry empties the queue.
// - Byte bits: 7 oper, 5 std, 4 output, 3 ques, 1/0 hw, 2 unused.
// - Serial poll reports request flag in bit 6 then clears it.
// - Query reports bit 6 as OR of byte ANDed with request enables.
module srg_top #(
  parameter int QDEPTH = 8,
  parameter int QW     = 8
) (
  input  wire logic          i_clk,
  input  wire logic          i_reset_n,
  input  wire logic [15:0]   i_oper_cond,
  input  wire logic [15:0]   i_ques_cond,
  input  wire logic [15:0]   i_hw1_cond,
  input  wire logic [15:0]   i_hw2_cond,
  input  wire logic [7:0]    i_std_event,
  input  wire logic          i_out_msg_avail,
  input  wire logic          i_err_push,
  input  wire logic [QW-1:0] i_err_code,
  input  wire logic          i_cmd_valid,
  input  wire logic [3:0]    i_cmd_code,
  input  wire logic [2:0]    i_cmd_group,
  input  wire logic [15:0]   i_cmd_wdata,
  output logic               o_rsp_valid,
  output logic [15:0]        o_rsp_data,
  output logic               o_srq,
  output logic [7:0]         o_status_byte
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic                         rsp_valid;
    logic [15:0]                  rsp_data;
    logic                         service_request_flag;
    logic                         mss_prev;
    logic [7:0]                   sre;
    logic [QDEPTH-1:0][QW-1:0]    q;
    logic [$clog2(QDEPTH+1)-1:0]  qcnt;
  } srg_top_s;

  localparam logic [$clog2(QDEPTH+1)-1:0] QFULL =
    ($clog2(QDEPTH+1))'(QDEPTH);

  srg_top_s                       st_ff;
  srg_top_s                       nxt_st;
  srg_pkg::srg_cmd_e              cmd;
  logic [srg_pkg::NGRP-1:0][15:0] g_cond_in;
  logic [srg_pkg::NGRP-1:0][15:0] g_set;
  logic [srg_pkg::NGRP-1:0][15:0] g_cond;
  logic [srg_pkg::NGRP-1:0][15:0] g_rise;
  logic [srg_pkg::NGRP-1:0][15:0] g_fall;
  logic [srg_pkg::NGRP-1:0][15:0] g_event;
  logic [srg_pkg::NGRP-1:0][15:0] g_mask;
  logic [srg_pkg::NGRP-1:0]       g_sum;
  logic [srg_pkg::NGRP-1:0]       g_sel;
  logic                           clr_stat;
  logic                           rst_cmd;
  logic                           q_nonempty;
  logic                           q_pop;
  logic [7:0]                     sbyte;
  logic                           master_summary_bit;

  assign cmd      = srg_pkg::srg_cmd_e'(i_cmd_code);
  assign clr_stat = i_cmd_valid && cmd == srg_pkg::CMD_CLR_STAT;
  assign rst_cmd  = i_cmd_valid && cmd == srg_pkg::CMD_RESET;
  assign q_pop    = i_cmd_valid && cmd == srg_pkg::CMD_RD_ERRQ &&
                    q_nonempty;
  // Queue summary follows its fill level.
  assign q_nonempty = st_ff.qcnt != '0;

  // ****************************************************************
  // Group inputs; the queue summary sits in the questionable group
  // ****************************************************************
  // Queue summary drives a condition bit, one level of hierarchy.
  always_comb begin
    g_cond_in = '0;
    g_set     = '0;
    g_cond_in[srg_pkg::GRP_OPER] = i_oper_cond;
    g_cond_in[srg_pkg::GRP_QUES] = i_ques_cond;
    g_cond_in[srg_pkg::GRP_QUES][srg_pkg::QUES_ERRQ_BIT] = q_nonempty;
    g_cond_in[srg_pkg::GRP_HW1]  = i_hw1_cond;
    g_cond_in[srg_pkg::GRP_HW2]  = i_hw2_cond;
    g_set[srg_pkg::GRP_STD]      = {8'h00, i_std_event};
  end

  // ****************************************************************
  // Register groups
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < srg_pkg::NGRP; gi = gi + 1) begin : g_grp
      localparam logic [15:0] UMASK =
        (gi == srg_pkg::GRP_STD)  ? srg_pkg::USED_8 :
        (gi == srg_pkg::GRP_OPER) ? srg_pkg::USED_OPER :
        srg_pkg::USED_16;
      assign g_sel[gi] = i_cmd_valid && i_cmd_group == 3'(gi);
      srg_group #(
        .USED (UMASK)
      ) u_grp (
        .i_clk        (i_clk),
        .i_reset_n    (i_reset_n),
        .i_cond       (g_cond_in[gi]),
        .i_set        (g_set[gi]),
        .i_clr_status (clr_stat),
        .i_reset_cmd  (rst_cmd),
        .i_rd_event   (g_sel[gi] && cmd == srg_pkg::CMD_RD_EVENT),
        .i_wr_rise    (g_sel[gi] && cmd == srg_pkg::CMD_WR_RISE),
        .i_wr_fall    (g_sel[gi] && cmd == srg_pkg::CMD_WR_FALL),
        .i_wr_mask    (g_sel[gi] && cmd == srg_pkg::CMD_WR_MASK),
        .i_wdata      (i_cmd_wdata),
        .o_cond       (g_cond[gi]),
        .o_rise       (g_rise[gi]),
        .o_fall       (g_fall[gi]),
        .o_event      (g_event[gi]),
        .o_mask       (g_mask[gi]),
        .o_summary    (g_sum[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Summary byte
  // ****************************************************************
  // Byte is pure wiring of summaries, so no write path exists.
  always_comb begin
    sbyte                   = 8'h00;
    sbyte[srg_pkg::SB_OPER] = g_sum[srg_pkg::GRP_OPER];
    sbyte[srg_pkg::SB_STD]  = g_sum[srg_pkg::GRP_STD];
    sbyte[srg_pkg::SB_MAV]  = i_out_msg_avail;
    sbyte[srg_pkg::SB_QUES] = g_sum[srg_pkg::GRP_QUES];
    sbyte[srg_pkg::SB_HW2]  = g_sum[srg_pkg::GRP_HW2];
    sbyte[srg_pkg::SB_HW1]  = g_sum[srg_pkg::GRP_HW1];
  end
  // Master summary excludes bit 6 itself.
  assign master_summary_bit = |(sbyte & st_ff.sre & srg_pkg::SB_NOT_SUM);

  // ****************************************************************
  // Command handling, request flag and error queue
  // ****************************************************************
  // Responses are registered one cycle after the command is taken.
  always_comb begin
    nxt_st           = st_ff;
    nxt_st.rsp_valid = 1'b0;
    nxt_st.mss_prev  = master_summary_bit;
    if (i_cmd_valid) begin
      case (cmd)
        srg_pkg::CMD_RD_COND: begin
          nxt_st.rsp_valid = 1'b1;
          nxt_st.rsp_data  = g_sel == '0 ? 16'h0000 : g_cond[i_cmd_group];
        end
        srg_pkg::CMD_RD_RISE: begin
          nxt_st.rsp_valid = 1'b1;
          nxt_st.rsp_data  = g_sel == '0 ? 16'h0000 : g_rise[i_cmd_group];
        end
        srg_pkg::CMD_RD_FALL: begin
          nxt_st.rsp_valid = 1'b1;
          nxt_st.rsp_data  = g_sel == '0 ? 16'h0000 : g_fall[i_cmd_group];
        end
        srg_pkg::CMD_RD_EVENT: begin
          nxt_st.rsp_valid = 1'b1;
          nxt_st.rsp_data  = g_sel == '0 ? 16'h0000 : g_event[i_cmd_group];
        end
        srg_pkg::CMD_RD_MASK: begin
          nxt_st.rsp_valid = 1'b1;
          nxt_st.rsp_data  = g_sel == '0 ? 16'h0000 : g_mask[i_cmd_group];
        end
        srg_pkg::CMD_STB_QRY: begin
          nxt_st.rsp_valid = 1'b1;
          nxt_st.rsp_data  = {8'h00, sbyte[7], master_summary_bit, sbyte[5:0]};
        end
        srg_pkg::CMD_SPOLL: begin
          nxt_st.rsp_valid = 1'b1;
          nxt_st.rsp_data  = {8'h00, sbyte[7], st_ff.service_request_flag, sbyte[5:0]};
          nxt_st.service_request_flag       = 1'b0;
        end
        srg_pkg::CMD_RD_SRE: begin
          nxt_st.rsp_valid = 1'b1;
          nxt_st.rsp_data  = {8'h00, st_ff.sre};
        end
        srg_pkg::CMD_WR_SRE: begin
          nxt_st.sre = i_cmd_wdata[7:0] & srg_pkg::SB_NOT_SUM;
        end
        srg_pkg::CMD_RD_ERRQ: begin
          nxt_st.rsp_valid = 1'b1;
          nxt_st.rsp_data  = q_nonempty ? {8'h00, st_ff.q[0]} : 16'h0000;
        end
        default: begin
        end
      endcase
    end
    // A new reason to request service beats a poll in the same cycle.
    if (master_summary_bit && !st_ff.mss_prev) nxt_st.service_request_flag = 1'b1;
    // Pop shifts the oldest entry out; reading all empties it.
    if (q_pop) begin
      for (int k = 0; k < QDEPTH - 1; k++) begin
        nxt_st.q[k] = st_ff.q[k+1];
      end
      nxt_st.qcnt = st_ff.qcnt - 1'b1;
    end
    // Clear-status empties the error queue only; output queue is
    // outside this block so its summary is untouched.
    if (clr_stat) nxt_st.qcnt = '0;
    // Overflow drops the newest entry; the oldest errors matter most.
    if (i_err_push && nxt_st.qcnt != QFULL) begin
      nxt_st.q[nxt_st.qcnt] = i_err_code;
      nxt_st.qcnt = nxt_st.qcnt + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_rsp_valid   = st_ff.rsp_valid;
  assign o_rsp_data    = st_ff.rsp_data;
  assign o_srq         = st_ff.service_request_flag;
  assign o_status_byte = {sbyte[7], st_ff.service_request_flag, sbyte[5:0]};

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  property p_qry_bit6;
    i_cmd_valid && cmd == srg_pkg::CMD_STB_QRY |=>
      o_rsp_valid && o_rsp_data[6] == $past(master_summary_bit) &&
      o_rsp_data[2] == 1'b0;
  endproperty
  a_qry_bit6: assert property (p_qry_bit6)
    else $error("Query bit 6 does not match master summary.");

  property p_poll_clr;
    i_cmd_valid && cmd == srg_pkg::CMD_SPOLL && !(master_summary_bit && !st_ff.mss_prev)
      |=> !o_srq && o_rsp_data[6] == $past(st_ff.service_request_flag);
  endproperty
  a_poll_clr: assert property (p_poll_clr)
    else $error("Serial poll did not report and clear request flag.");

  property p_mav_keep;
    clr_stat && i_out_msg_avail |=> o_status_byte[srg_pkg::SB_MAV];
  endproperty
  a_mav_keep: assert property (p_mav_keep)
    else $error("Output message bit lost on clear-status.");

  property p_q_empty;
    clr_stat && !i_err_push |=> !q_nonempty &&
      !g_cond[srg_pkg::GRP_QUES][srg_pkg::QUES_ERRQ_BIT];
  endproperty
  a_q_empty: assert property (p_q_empty)
    else $error("Queue summary stays set after clear-status.");

  // A read that is not racing a push or a clear drops exactly one entry.
  property p_q_pop;
    q_pop && !i_err_push && !clr_stat |=>
      st_ff.qcnt == $past(st_ff.qcnt) - 1'b1;
  endproperty
  a_q_pop: assert property (p_q_pop)
    else $error("Error queue did not shrink on read.");

  // A new reason for service always raises the flag, even during a poll.
  property p_rqs_set;
    master_summary_bit && !st_ff.mss_prev |=> o_srq;
  endproperty
  a_rqs_set: assert property (p_rqs_set)
    else $error("Request flag not raised on new service reason.");

  // A status query reports the summary but must leave the flag alone.
  property p_qry_keep;
    i_cmd_valid && cmd == srg_pkg::CMD_STB_QRY && !(master_summary_bit && !st_ff.mss_prev)
      |=> o_srq == $past(st_ff.service_request_flag);
  endproperty
  a_qry_keep: assert property (p_qry_keep)
    else $error("Status query disturbed the request flag.");

  c_poll: cover property (o_srq ##1 i_cmd_valid && cmd == srg_pkg::CMD_SPOLL);
  c_qfull: cover property (st_ff.qcnt == QFULL);

endmodule

/* File: verification/srg_ctrl_model.sv */
// Behavioural remote controller that issues decoded status commands.
// Assumes the bench calls its tasks; each command launches at a fall.
`timescale 1ns/100ps
module srg_ctrl_model (
  input  wire logic        i_clk,
  input  wire logic        i_rsp_valid,
  input  wire logic [15:0] i_rsp_data,
  output logic             o_cmd_valid,
  output logic [3:0]       o_cmd_code,
  output logic [2:0]       o_cmd_group,
  output logic [15:0]      o_cmd_wdata
);
  // ****************************************************************
  // Command launch and answer capture
  // ****************************************************************
  // Idle qualifiers start from a known value at time zero.
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_code  = 4'hF;
    o_cmd_group = 3'h7;
    o_cmd_wdata = 16'h0000;
  end

  // Between commands the qualifiers are inverted, so that a stale
  // value can never pass for a fresh one.
  task automatic send(input logic [3:0] c, input logic [2:0] g,
                      input logic [15:0] d);
    @(negedge i_clk);
    o_cmd_valid = 1'b1;
    o_cmd_code  = c;
    o_cmd_group = g;
    o_cmd_wdata = d;
    @(negedge i_clk);
    o_cmd_valid = 1'b0;
    o_cmd_code  = ~c;
    o_cmd_group = ~g;
    o_cmd_wdata = ~d;
  endtask

  // The answer stands one cycle only, so it is taken while it stands.
  task automatic query(input logic [3:0] c, input logic [2:0] g,
                       output logic [15:0] q);
    send(c, g, 16'h0000);
    q = (i_rsp_valid === 1'b1) ? i_rsp_data : 16'hXXXX;
  endtask

  // The query result is split into byte and summary by masking.
  task automatic stb(output logic [7:0] sb, output logic master_summary_bit);
    logic [15:0] q;
    query(srg_pkg::CMD_STB_QRY, 3'h0, q);
    sb  = q[7:0] & 8'hBF;
    master_summary_bit = |(q[7:0] & 8'h40);
  endtask
endmodule

/* File: verification/tb.sv */
// Self-checking bench for the status reporting top.
// Assumes the controller model drives the command port.
`timescale 1ns/100ps
`define CHK(g, e) \
  begin \
    n_checks++; \
    if ((g) !== (e)) begin \
      n_mismatch++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); \
    end \
  end
module tb;
  logic        i_clk;
  logic        i_reset_n;
  logic [15:0] oper, ques, hw1, hw2;
  logic [7:0]  stde, ecode, sb, sbyte;
  logic        output_message_available, epush, cv, rv, srq, master_summary_bit;
  logic [3:0]  cc;
  logic [2:0]  cg;
  logic [15:0] cw, rd, q;
  int          n_mismatch = 0;
  int          n_checks   = 0;
  localparam logic [2:0] GMAP [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
  localparam int         BMAP [5] = '{7, 3, 0, 1, 5};

  // ****************************************************************
  // Instances and clock
  // ****************************************************************
  srg_top #(.QDEPTH(8), .QW(8)) srg_top_inst (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_oper_cond(oper),
    .i_ques_cond(ques), .i_hw1_cond(hw1), .i_hw2_cond(hw2),
    .i_std_event(stde), .i_out_msg_avail(output_message_available), .i_err_push(epush),
    .i_err_code(ecode), .i_cmd_valid(cv), .i_cmd_code(cc),
    .i_cmd_group(cg), .i_cmd_wdata(cw), .o_rsp_valid(rv),
    .o_rsp_data(rd), .o_srq(srq), .o_status_byte(sbyte));
  srg_ctrl_model srg_ctrl_model_inst (
    .i_clk(i_clk), .i_rsp_valid(rv), .i_rsp_data(rd),
    .o_cmd_valid(cv), .o_cmd_code(cc), .o_cmd_group(cg),
    .o_cmd_wdata(cw));

  // Free-running 20 MHz clock.
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic wt(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic wr(input logic [3:0] c, input logic [2:0] g,
                    input logic [15:0] d);
    srg_ctrl_model_inst.send(c, g, d);
  endtask
  task automatic rdc(input logic [3:0] c, input logic [2:0] g,
                     input logic [15:0] e);
    srg_ctrl_model_inst.query(c, g, q);
    `CHK(q, e)
  endtask
  task automatic push(input logic [7:0] c);
    ecode = c;
    epush = 1'b1;
    wt(1);
    epush = 1'b0;
    wt(1);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Defaults, live condition read and the unassigned top bit.
  task automatic t_reset();
    rdc(srg_pkg::CMD_RD_RISE, 3'h2, 16'hFFFF);
    rdc(srg_pkg::CMD_RD_FALL, 3'h2, 16'h0000);
    rdc(srg_pkg::CMD_RD_MASK, 3'h2, 16'h0000);
    oper = 16'hFFFF;
    rdc(srg_pkg::CMD_RD_COND, 3'h0, 16'h7FFF);
    rdc(srg_pkg::CMD_RD_EVENT, 3'h0, 16'h7FFF);
    rdc(srg_pkg::CMD_RD_EVENT, 3'h0, 16'h0000);
    oper = 16'h0000;
    rdc(srg_pkg::CMD_RD_EVENT, 3'h0, 16'h0000);
  endtask

  // Bit 0 rise only, bit 1 fall only, bit 2 both, bit 3 neither.
  task automatic t_filt();
    wr(srg_pkg::CMD_WR_RISE, 3'h2, 16'h0005);
    wr(srg_pkg::CMD_WR_FALL, 3'h2, 16'h0006);
    rdc(srg_pkg::CMD_RD_RISE, 3'h2, 16'h0005);
    rdc(srg_pkg::CMD_RD_FALL, 3'h2, 16'h0006);
    hw1 = 16'h000F;
    rdc(srg_pkg::CMD_RD_EVENT, 3'h2, 16'h0005);
    hw1 = 16'h0000;
    rdc(srg_pkg::CMD_RD_EVENT, 3'h2, 16'h0006);
  endtask

  // A latched bit ignores further edges and feeds the byte.
  task automatic t_latch();
    wr(srg_pkg::CMD_WR_MASK, 3'h2, 16'h0004);
    hw1 = 16'h0004;
    wt(2);
    `CHK(sbyte[0], 1'b1)
    for (int i = 0; i < 4; i++) begin
      hw1 = hw1 ^ 16'h0004;
      wt(2);
    end
    rdc(srg_pkg::CMD_RD_EVENT, 3'h2, 16'h0004);
    rdc(srg_pkg::CMD_RD_EVENT, 3'h2, 16'h0000);
    `CHK(sbyte[0], 1'b0)
    rdc(srg_pkg::CMD_RD_MASK, 3'h2, 16'h0004);
  endtask

  // Error queue fills, reports, and empties as it is read out.
  task automatic t_queue();
    push(8'h5A);
    push(8'h3C);
    rdc(srg_pkg::CMD_RD_COND, 3'h1, 16'h0200);
    rdc(srg_pkg::CMD_RD_ERRQ, 3'h1, 16'h005A);
    rdc(srg_pkg::CMD_RD_COND, 3'h1, 16'h0200);
    rdc(srg_pkg::CMD_RD_ERRQ, 3'h1, 16'h003C);
    rdc(srg_pkg::CMD_RD_COND, 3'h1, 16'h0000);
  endtask

  // Clear-status spares filters, masks and the output queue bit.
  task automatic t_clear();
    hw1 = 16'h0000;
    output_message_available = 1'b1;
    push(8'hC3);
    wt(2);
    `CHK(sbyte[0], 1'b1)
    wr(srg_pkg::CMD_CLR_STAT, 3'h0, 16'h0000);
    rdc(srg_pkg::CMD_RD_EVENT, 3'h2, 16'h0000);
    rdc(srg_pkg::CMD_RD_COND, 3'h1, 16'h0000);
    `CHK(sbyte, 8'h10)
    rdc(srg_pkg::CMD_RD_MASK, 3'h2, 16'h0004);
    rdc(srg_pkg::CMD_RD_RISE, 3'h2, 16'h0005);
    rdc(srg_pkg::CMD_RD_FALL, 3'h2, 16'h0006);
  endtask

  // Every group summary lands on its own byte bit.
  task automatic t_map();
    logic [7:0] e;
    for (int i = 0; i < 5; i++)
      wr(srg_pkg::CMD_WR_MASK, GMAP[i], 16'hFFFF);
    rdc(srg_pkg::CMD_RD_MASK, 3'h4, 16'h00FF);
    rdc(srg_pkg::CMD_RD_MASK, 3'h0, 16'h7FFF);
    rdc(srg_pkg::CMD_RD_MASK, 3'h5, 16'h0000);
    {oper, ques, hw1, hw2} = {4{16'h0001}};
    stde = 8'h01;
    wt(1);
    stde = 8'h00;
    wt(1);
    e = 8'hBB;
    `CHK(sbyte, e)
    for (int i = 0; i < 5; i++) begin
      rdc(srg_pkg::CMD_RD_EVENT, GMAP[i], 16'h0001);
      e[BMAP[i]] = 1'b0;
      `CHK(sbyte, e)
    end
    // A fresh edge in the very cycle of the read survives its clear.
    fork
      rdc(srg_pkg::CMD_RD_EVENT, 3'h3, 16'h0000);
      begin
        wt(1);
        hw2 = 16'h0003;
      end
    join
    rdc(srg_pkg::CMD_RD_EVENT, 3'h3, 16'h0002);
  endtask

  // Request flag by query and by serial poll.
  task automatic t_srq();
    wr(srg_pkg::CMD_WR_SRE, 3'h0, 16'h0001);
    rdc(srg_pkg::CMD_RD_SRE, 3'h0, 16'h0001);
    hw1 = 16'h0000;
    wt(1);
    hw1 = 16'h0001;
    wt(3);
    `CHK(srq, 1'b1)
    srg_ctrl_model_inst.stb(sb, master_summary_bit);
    `CHK({sb, master_summary_bit}, {8'h11, 1'b1})
    rdc(srg_pkg::CMD_SPOLL, 3'h0, 16'h0051);
    `CHK({srq, sbyte}, {1'b0, 8'h11})
    srg_ctrl_model_inst.stb(sb, master_summary_bit);
    `CHK(master_summary_bit, 1'b1)
    wr(srg_pkg::CMD_RESET, 3'h0, 16'h0000);
    rdc(srg_pkg::CMD_RD_RISE, 3'h2, 16'hFFFF);
    rdc(srg_pkg::CMD_RD_FALL, 3'h2, 16'h0000);
  endtask

  // ****************************************************************
  // Sequence, verdict and watchdog
  // ****************************************************************
  task automatic summarize();
    if (n_mismatch == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Inputs settle at time zero; reset is held for ten cycles.
  initial begin
    {oper, ques, hw1, hw2} = '0;
    {stde, ecode, output_message_available, epush} = '0;
    i_reset_n = 1'b0;
    wt(10);
    i_reset_n = 1'b1;
    wt(1);
    `CHK(sbyte, 8'h00)
    t_reset();
    t_filt();
    t_latch();
    t_queue();
    t_clear();
    t_map();
    t_srq();
    summarize();
  end

  // The run needs well under a thousand cycles; this bound is ample.
  initial begin
    #(50 * 5000);
    n_mismatch++;
    summarize();
  end
endmodule
